// file: rtl/quad_pkg.sv
// Shared constants and carrier types for the three-axis quadrature decoder.
// Assumes a single 100 MHz clock and synchronous active-low reset.
package quad_pkg;
    localparam int          NUM_AXES      = 3;
    localparam int          CNT_W         = 16;
    localparam logic [15:0] CNT_RST       = 16'h0000;
    localparam int          CLK_MHZ       = 100;
    // Sample rates in kHz, selected by rate_sel
    localparam int          RATE0_KHZ     = 26000;
    localparam int          RATE1_KHZ     = 13000;
    localparam int          RATE2_KHZ     = 6500;
    localparam int          RATE3_KHZ     = 3250;
    // Cycles between sample enables, rounded down, so each rate runs fast, the fastest near 33 MHz
    localparam int          DIV0          = (CLK_MHZ * 1000) / RATE0_KHZ;
    localparam int          DIV1          = (CLK_MHZ * 1000) / RATE1_KHZ;
    localparam int          DIV2          = (CLK_MHZ * 1000) / RATE2_KHZ;
    localparam int          DIV3          = (CLK_MHZ * 1000) / RATE3_KHZ;
    localparam int          DIV_W         = 6;
    localparam logic [1:0]  RATE_RST      = 2'h0;

    typedef struct packed {
        logic phase_a;
        logic phase_b;
    } quad_pins_t;

    typedef struct packed {
        logic [CNT_W-1:0] fwd;
        logic [CNT_W-1:0] rev;
    } thresh_t;

    typedef enum logic [1:0] {
        DIR_IDLE = 2'b00,
        DIR_FWD  = 2'b01,
        DIR_REV  = 2'b10
    } dir_t;
endpackage

// file: rtl/quad_axis.sv
// One axis: synchroniser, edge and phase detection, counter and threshold flags.
// Assumes sample_en is a one-cycle pulse from the shared rate divider.
`timescale 1ns/1ns
module quad_axis
    import quad_pkg::*;
#(
    parameter int W = CNT_W
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         sample_en,
    input  wire quad_pins_t   pins,
    input  wire logic [W-1:0] thr_fwd,
    input  wire logic [W-1:0] thr_rev,
    input  wire logic         clear,
    output logic [W-1:0]      count,
    output dir_t              dir,
    output logic              hit_fwd,
    output logic              hit_rev
);
    quad_pins_t meta_q;
    quad_pins_t sync_q;
    quad_pins_t prev_q;
    logic       step_up;
    logic       step_dn;

    // Three stages on the sample enable; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else if (sample_en) begin
            meta_q <= pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Every edge of one phase alone is a step, none when both change in one sample; direction from which phase leads
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if (sample_en && (sync_q != prev_q) && !((sync_q.phase_a != prev_q.phase_a) &&
                (sync_q.phase_b != prev_q.phase_b))) begin
            // A leads B: new A differs from old B
            if ((sync_q.phase_a ^ prev_q.phase_b) == 1'b1) begin
                step_up = 1'b1;
            end else begin
                step_dn = 1'b1;
            end
        end
    end

    // Unsigned counter wrapping modulo 2^W; a step outranks a clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= CNT_RST;
        end else if (step_up) begin
            count <= count + W'(1);
        end else if (step_dn) begin
            count <= count - W'(1);
        end else if (clear) begin
            count <= CNT_RST;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir <= DIR_IDLE;
        end else if (step_up) begin
            dir <= DIR_FWD;
        end else if (step_dn) begin
            dir <= DIR_REV;
        end
    end

    // One-cycle pulses when the count reaches the threshold of its own direction
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hit_fwd <= 1'b0;
            hit_rev <= 1'b0;
        end else begin
            hit_fwd <= step_up && (count + W'(1) == thr_fwd);
            hit_rev <= step_dn && (count - W'(1) == thr_rev);
        end
    end

    chk_hit_fwd_cause: assert property (@(posedge clk) disable iff (!rst_n)
        hit_fwd |-> (count == thr_fwd) && (dir == DIR_FWD))
        else $error("forward hit without matching count");
    chk_hit_rev_cause: assert property (@(posedge clk) disable iff (!rst_n)
        hit_rev |-> (count == thr_rev) && (dir == DIR_REV))
        else $error("reverse hit without matching count");
    chk_count_step: assert property (@(posedge clk) disable iff (!rst_n)
        !sample_en |=> $stable(count) || count == CNT_RST)
        else $error("count moved without a sample");
    chk_count_up_one: assert property (@(posedge clk) disable iff (!rst_n)
        step_up |=> count == $past(count) + W'(1))
        else $error("up step not plus one");
    chk_sync_latency: assert property (@(posedge clk) disable iff (!rst_n)
        sample_en |=> sync_q == $past(meta_q))
        else $error("sync stage skipped");
endmodule

// file: rtl/quad_decoder.sv
// Three-axis quadrature decoder top: rate divider, three axis channels, interrupt.
// Assumes sensor pins are already routed to this block; software settings are plain ports.
//
// Function
// - Three independent axes X, Y, Z, each with two input pins.
// - Direction of motion follows which input of an axis leads.
// - Every edge of either input of an axis is counted, except when both inputs change in one sample.
// - Each axis keeps its own unsigned 16-bit count.
// - Interrupt when a count reaches its per-direction threshold.
// - Sampling rate selectable among nominal 26, 13, 6.5 and 3.25 MHz, run as about 33.3, 14.3, 6.7 and 3.3 MHz.
// - Wakeup only for the axis routed through the always-on pin.
`timescale 1ns/1ns
module quad_decoder
    import quad_pkg::*;
#(
    parameter int AXES = NUM_AXES,
    parameter int W    = CNT_W
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire quad_pins_t [AXES-1:0]  axis_pins,
    input  wire logic [1:0]             rate_sel,
    input  wire thresh_t [AXES-1:0]     thresholds,
    input  wire logic [AXES-1:0]        count_clear,
    input  wire logic [AXES-1:0]        irq_clear,
    input  wire logic [1:0]             wake_axis,
    input  wire logic                   sleep_mode,
    output logic [AXES-1:0][W-1:0]      counts,
    output dir_t [AXES-1:0]             dirs,
    output logic [AXES-1:0]             irq_pending,
    output logic                        irq,
    output logic                        wake
);
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_lim;
    logic             sample_en;
    logic [AXES-1:0]  hit;

    always_comb begin
        case (rate_sel)
            2'h0:    div_lim = DIV_W'(DIV0 - 1);
            2'h1:    div_lim = DIV_W'(DIV1 - 1);
            2'h2:    div_lim = DIV_W'(DIV2 - 1);
            2'h3:    div_lim = DIV_W'(DIV3 - 1);
            default: div_lim = DIV_W'(DIV0 - 1);
        endcase
    end

    // 100 MHz is not a multiple of 26 MHz, so the fastest rate lands at about 33 MHz
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (div_q >= div_lim) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end
    assign sample_en = (div_q >= div_lim);

    // Checker-only: cycles since the last sample, and whether the rate held still since it
    logic [DIV_W-1:0] gap_q;
    logic [1:0]       rate_q;
    logic             rate_held_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gap_q <= '0;
        end else if (sample_en) begin
            gap_q <= '0;
        end else begin
            gap_q <= gap_q + DIV_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rate_q      <= RATE_RST;
            rate_held_q <= 1'b0;
        end else begin
            rate_q <= rate_sel;
            if (sample_en) begin
                rate_held_q <= 1'b1;
            end else if (rate_sel != rate_q) begin
                rate_held_q <= 1'b0;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            logic hf;
            logic hr;
            quad_axis #(.W(W)) u_axis (
                .clk       (clk),
                .rst_n     (rst_n),
                .sample_en (sample_en),
                .pins      (axis_pins[g]),
                .thr_fwd   (thresholds[g].fwd),
                .thr_rev   (thresholds[g].rev),
                .clear     (count_clear[g]),
                .count     (counts[g]),
                .dir       (dirs[g]),
                .hit_fwd   (hf),
                .hit_rev   (hr)
            );
            assign hit[g] = hf | hr;

            // Sticky pending; a new hit wins over a clear in the same cycle
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    irq_pending[g] <= 1'b0;
                end else if (hit[g]) begin
                    irq_pending[g] <= 1'b1;
                end else if (irq_clear[g]) begin
                    irq_pending[g] <= 1'b0;
                end
            end

            // Per-axis checks on the pending flag and the count it follows
            chk_pend_set: assert property (@(posedge clk) disable iff (!rst_n)
                hit[g] |=> irq_pending[g])
                else $error("pending flag missed a hit");
            chk_pend_hold: assert property (@(posedge clk) disable iff (!rst_n)
                (irq_pending[g] && !irq_clear[g]) |=> irq_pending[g])
                else $error("pending flag dropped without a clear");
            chk_pend_drop: assert property (@(posedge clk) disable iff (!rst_n)
                (irq_clear[g] && !hit[g]) |=> !irq_pending[g])
                else $error("pending flag survived a clear");
            chk_pend_rise: assert property (@(posedge clk) disable iff (!rst_n)
                $rose(irq_pending[g]) |-> $past(hit[g]))
                else $error("pending flag rose without a hit");
            chk_hit_one_dir: assert property (@(posedge clk) disable iff (!rst_n)
                !(hf && hr))
                else $error("both direction hits at once");
            chk_count_idle: assert property (@(posedge clk) disable iff (!rst_n)
                (!sample_en && !count_clear[g]) |=> $stable(counts[g]))
                else $error("axis count moved on its own");
            chk_clear_zero: assert property (@(posedge clk) disable iff (!rst_n)
                (count_clear[g] && !sample_en) |=> counts[g] == '0)
                else $error("clear did not zero the count");
            chk_count_delta: assert property (@(posedge clk) disable iff (!rst_n)
                sample_en |=> $stable(counts[g]) || counts[g] == '0 ||
                    counts[g] == $past(counts[g]) + W'(1) || counts[g] == $past(counts[g]) - W'(1))
                else $error("count moved by more than one step");
            chk_dir_idle: assert property (@(posedge clk) disable iff (!rst_n)
                !sample_en |=> $stable(dirs[g]))
                else $error("direction changed without a sample");
        end
    endgenerate

    // In sleep only the always-on pin's axis still reaches the wake output
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq  <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq  <= !sleep_mode && (|irq_pending);
            wake <= sleep_mode && (wake_axis < 2'(AXES)) && irq_pending[wake_axis];
        end
    end

    chk_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
        (!sleep_mode && |irq_pending) |=> irq)
        else $error("irq not raised for pending hit");
    chk_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        !(|irq_pending) |=> !irq)
        else $error("irq raised with nothing pending");
    chk_irq_cause: assert property (@(posedge clk) disable iff (!rst_n)
        irq |-> !$past(sleep_mode) && $past(|irq_pending))
        else $error("irq without an awake pending flag");
    chk_sleep_no_irq: assert property (@(posedge clk) disable iff (!rst_n)
        $past(sleep_mode) |-> !irq)
        else $error("irq raised in sleep");

    chk_wake_source: assert property (@(posedge clk) disable iff (!rst_n)
        wake |-> $past(sleep_mode) && $past(irq_pending[wake_axis]))
        else $error("wake without pending always-on axis");
    chk_wake_follows: assert property (@(posedge clk) disable iff (!rst_n)
        (sleep_mode && (wake_axis < 2'(AXES)) && irq_pending[wake_axis]) |=> wake)
        else $error("wake missed a pending always-on axis");
    chk_wake_awake: assert property (@(posedge clk) disable iff (!rst_n)
        !sleep_mode |=> !wake)
        else $error("wake raised while awake");
    chk_wake_none: assert property (@(posedge clk) disable iff (!rst_n)
        (wake_axis >= 2'(AXES)) |=> !wake)
        else $error("wake raised with no always-on axis");
    chk_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        (hit[0] && irq_clear[0]) |=> irq_pending[0])
        else $error("clear beat a hit");

    chk_div_period: assert property (@(posedge clk) disable iff (!rst_n)
        (sample_en && rate_sel == 2'h3 && $stable(rate_sel)) |=> !sample_en [*8])
        else $error("slowest rate sample too early");
    chk_sample_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        sample_en |=> !sample_en)
        else $error("sample enable longer than one cycle");
    chk_div_range: assert property (@(posedge clk) disable iff (!rst_n)
        div_q <= DIV_W'(DIV3 - 1))
        else $error("divider ran past the slowest limit");

    // Sample spacing per rate, judged only where the rate held since the last sample
    chk_rate0_gap: assert property (@(posedge clk) disable iff (!rst_n)
        (sample_en && rate_held_q && (rate_sel == rate_q) && (rate_sel == 2'h0))
            |-> gap_q == DIV_W'(DIV0 - 1))
        else $error("fastest rate sample spacing wrong");
    chk_rate1_gap: assert property (@(posedge clk) disable iff (!rst_n)
        (sample_en && rate_held_q && (rate_sel == rate_q) && (rate_sel == 2'h1))
            |-> gap_q == DIV_W'(DIV1 - 1))
        else $error("second rate sample spacing wrong");
    chk_rate2_gap: assert property (@(posedge clk) disable iff (!rst_n)
        (sample_en && rate_held_q && (rate_sel == rate_q) && (rate_sel == 2'h2))
            |-> gap_q == DIV_W'(DIV2 - 1))
        else $error("third rate sample spacing wrong");
    chk_rate3_gap: assert property (@(posedge clk) disable iff (!rst_n)
        (sample_en && rate_held_q && (rate_sel == rate_q) && (rate_sel == 2'h3))
            |-> gap_q == DIV_W'(DIV3 - 1))
        else $error("slowest rate sample spacing wrong");
endmodule

// file: tb/quad_sensor.sv
// Behavioural two-phase motion sensor for one axis.
// Assumes go is a one-clock request driven just after a rising edge.
`timescale 1ns/1ns
module quad_sensor
    import quad_pkg::*;
(
    input  wire logic clk,
    input  wire logic go,
    input  wire logic fwd,
    output quad_pins_t pins
);
    logic [1:0] pos_q = 2'h0;

    // One state per request, so only one phase ever changes at a time
    always_ff @(posedge clk) begin
        if (go) begin
            pos_q <= fwd ? pos_q + 2'h1 : pos_q - 2'h1;
        end
    end

    // Forward order makes phase_a lead phase_b by a quarter period
    assign pins = {pos_q[0] ^ pos_q[1], pos_q[1]};
endmodule

// file: tb/tb.sv
// Self-checking bench for the three-axis quadrature decoder.
// Assumes the sensor model drives the pins and one step settles in 100 clocks.
`timescale 1ns/1ns
module tb;
    import quad_pkg::*;
    logic              clk       = 1'b0;
    logic              rst_n     = 1'b0;
    quad_pins_t [2:0]  pins;
    logic [2:0]        go        = 3'h0;
    logic              fwd       = 1'b1;
    logic [1:0]        rate_sel  = 2'h0;
    thresh_t [2:0]     thr       = {6{16'h0000}};
    logic [2:0]        cclr      = 3'h0;
    logic [2:0]        iclr      = 3'h0;
    logic [1:0]        wake_axis = 2'h3;
    logic              sleep     = 1'b0;
    logic [2:0][15:0]  counts;
    dir_t [2:0]        dirs;
    logic [2:0]        pend;
    logic              irq;
    logic              wake;
    int                n_fail    = 0;
    int                n_checks  = 0;
    logic              seen_pend0 = 1'b0;

    always #5 clk = ~clk;

    quad_decoder u_dut (.clk(clk), .rst_n(rst_n), .axis_pins(pins), .rate_sel(rate_sel),
        .thresholds(thr), .count_clear(cclr), .irq_clear(iclr), .wake_axis(wake_axis),
        .sleep_mode(sleep), .counts(counts), .dirs(dirs), .irq_pending(pend), .irq(irq), .wake(wake));

    for (genvar g = 0; g < 3; g++) begin : g_sen
        quad_sensor u_sen (.clk(clk), .go(go[g]), .fwd(fwd), .pins(pins[g]));
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Pending rising under a held clear shows the hit won that cycle
    always @(posedge clk) begin
        if (pend[0] && iclr[0]) begin
            seen_pend0 <= 1'b1;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Pulse n requests, each followed by a wait of w clocks
    task automatic step(input int a, input logic f, input int n, input int w);
        repeat (n) begin
            fwd   <= f;
            go[a] <= 1'b1;
            tick(1);
            go[a] <= 1'b0;
            tick(w);
        end
    endtask

    task automatic t_fwd();
        step(0, 1'b1, 5, 100);
        chk(counts[0], 64'h5);
        chk(dirs[0], DIR_FWD);
        chk(counts[2:1], 64'h0);
        step(0, 1'b0, 1, 100);
        chk(counts[0], 64'h4);
        chk(dirs[0], DIR_REV);
    endtask

    task automatic t_wrap_clear();
        step(1, 1'b0, 2, 100);
        chk(counts[1], 64'hFFFE);
        step(1, 1'b1, 3, 100);
        chk(counts[1], 64'h1);
        chk(pend, 64'h2);
        cclr  <= 3'h3;
        iclr  <= 3'h2;
        tick(1);
        cclr  <= 3'h0;
        iclr  <= 3'h0;
        tick(3);
        chk(counts[1:0], 64'h0);
        chk(pend, 64'h0);
    endtask

    task automatic t_thresh();
        thr[2] <= {16'h0003, 16'h0001};
        step(2, 1'b1, 2, 100);
        chk(pend, 64'h0);
        step(2, 1'b1, 1, 100);
        chk({pend, irq}, 64'h9);
        iclr  <= 3'h4;
        tick(1);
        iclr  <= 3'h0;
        tick(3);
        chk({pend, irq}, 64'h0);
        step(2, 1'b0, 2, 100);
        chk(pend, 64'h4);
        sleep     <= 1'b1;
        wake_axis <= 2'h2;
        tick(4);
        chk({irq, wake}, 64'h1);
        wake_axis <= 2'h0;
        tick(4);
        chk({irq, wake}, 64'h0);
        sleep <= 1'b0;
        iclr  <= 3'h4;
        tick(4);
        iclr  <= 3'h0;
    endtask

    // Fast rate must count within 25 clocks, slowest rate must not
    task automatic t_rates();
        for (int r = 0; r < 4; r++) begin
            rate_sel <= r[1:0];
            tick(100);
            step(0, 1'b1, 1, 25);
            if (r == 0) chk(counts[0], 64'h1);
            if (r == 3) chk(counts[0], 64'h3);
            tick(75);
            chk(counts[0], r + 1);
        end
    endtask

    // Hold the clear across a hit: the pending flag must still rise for that cycle
    task automatic t_set_wins();
        thr[0] <= {16'h0005, 16'h0000};
        iclr   <= 3'h1;
        step(0, 1'b1, 1, 100);
        iclr   <= 3'h0;
        tick(3);
        chk(counts[0], 64'h5);
        chk(seen_pend0, 64'h1);
        chk(pend, 64'h0);
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        tick(20000);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        tick(6);
        rst_n <= 1'b1;
        tick(2);
        chk({counts, pend, irq, wake}, 64'h0);
        t_fwd();
        t_wrap_clear();
        t_thresh();
        t_rates();
        t_set_wins();
        tally_and_finish();
    end
endmodule
